// *** src/adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;
    localparam int RESULT_BITS = 12;
    localparam int CLK_SYS_HZ = 25000000;
    localparam int CONV_TIME_NS = 7500;
    // Longest time, rounded down to whole cycles
    localparam int CONV_CYCLES = (CONV_TIME_NS * (CLK_SYS_HZ / 1000000)) / 1000;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    // Falling edges that carry the marker and the result
    localparam logic [3:0] FRAME_EDGES = 4'hD;
    // Power-down control levels after pin decode
    typedef enum logic [1:0] {
        PD_LOW = 2'b00,
        PD_HIGH = 2'b01,
        PD_FLOAT = 2'b10
    } pd_level_e;
    // Gray coded conversion states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONVERT = 2'b01,
        ST_DONE = 2'b11
    } conv_state_e;
endpackage

// *** src/serial_adc_convert_readout.sv ***
module serial_adc_convert_readout
    import adc_ctrl_pkg::*;
#(
    parameter int CONV_COUNT = CONV_CYCLES
) (
    input wire logic clk_sys_in, // System clock, 25 MHz
    input wire logic srst_in, // Synchronous reset, high
    input wire logic sclk_in, // Serial shift clock from host
    input wire logic cs_n_in, // Chip select, active low
    input wire logic pd_drive_in, // Power-down pin driven (not floating)
    input wire logic pd_level_in, // Power-down pin level when driven
    input wire logic [11:0] sample_in, // Converter result from analog core
    output logic dout_out, // Serial data output
    output logic dout_oe_out, // Serial data output enable
    output logic track_out, // Track/hold tracking when high
    output logic ref_en_out, // Internal reference enable
    output logic shutdown_out // Device in shutdown
);
    // Refuse conversion times the cycle budget cannot serve
    if (CONV_COUNT < 1 || CONV_COUNT > CONV_CYCLES) begin : g_bad_count
        $error("CONV_COUNT out of range");
    end

    // ---------------- System clock domain ----------------
    logic [1:0] cs_sync;
    logic [1:0] pdd_sync;
    logic [1:0] pdl_sync;
    logic cs_prev;
    conv_state_e state;
    conv_state_e next_state;
    logic [15:0] conv_cnt;
    logic [15:0] next_conv_cnt;
    logic [11:0] result;
    logic [11:0] next_result;
    logic track;
    logic next_track;
    logic ref_en;
    logic next_ref_en;
    logic shut;
    logic next_shut;
    pd_level_e pd_lvl;

    // Input synchronisers
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            cs_sync <= 2'h3;
            pdd_sync <= 2'h0;
            pdl_sync <= 2'h0;
        end else begin
            cs_sync <= {cs_sync[0], cs_n_in};
            pdd_sync <= {pdd_sync[0], pd_drive_in};
            pdl_sync <= {pdl_sync[0], pd_level_in};
        end
    end

    // Three-level pin decode
    always_comb begin
        if (!pdd_sync[1]) begin
            pd_lvl = PD_FLOAT;
        end else if (pdl_sync[1]) begin
            pd_lvl = PD_HIGH;
        end else begin
            pd_lvl = PD_LOW;
        end
    end

    // Conversion sequencer next values
    always_comb begin
        next_state = state;
        next_conv_cnt = conv_cnt;
        next_result = result;
        next_track = track;
        next_shut = (pd_lvl == PD_LOW);
        next_ref_en = (pd_lvl == PD_HIGH);
        if (pd_lvl == PD_LOW) begin
            next_state = ST_IDLE;
            next_track = 1'b1;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cs_prev && !cs_sync[1]) begin
                        next_state = ST_CONVERT;
                        next_track = 1'b0;
                        next_conv_cnt = 16'h0000;
                    end
                end
                ST_CONVERT: begin
                    if (cs_sync[1]) begin
                        next_state = ST_IDLE; // Aborted conversion
                        next_track = 1'b1;
                    end else if (conv_cnt == 16'(CONV_COUNT - 1)) begin
                        next_state = ST_DONE;
                        next_result = sample_in;
                        next_track = 1'b1;
                    end else begin
                        next_conv_cnt = conv_cnt + 16'h0001;
                    end
                end
                ST_DONE: begin
                    if (cs_sync[1]) begin
                        next_state = ST_IDLE;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            cs_prev <= 1'b1;
            state <= ST_IDLE;
            conv_cnt <= 16'h0000;
            result <= RESULT_RESET;
            track <= 1'b1;
            ref_en <= 1'b0;
            shut <= 1'b0;
        end else begin
            cs_prev <= cs_sync[1];
            state <= next_state;
            conv_cnt <= next_conv_cnt;
            result <= next_result;
            track <= next_track;
            ref_en <= next_ref_en;
            shut <= next_shut;
        end
    end

    assign track_out = track;
    assign ref_en_out = ref_en;
    assign shutdown_out = shut;

    // ---------------- Serial clock domain ----------------
    // The host parks the serial clock during conversion and clocks only
    // after it has seen the end-of-conversion marker on the output.
    // The result word settles one system clock before that marker shows,
    // the ready level in the same clock, and both hold until chip select rises.
    // At every falling edge they are therefore quasi-static and the
    // link side may read them directly, with no synchroniser.
    // Going the other way, one bit crosses back through two flip-flops.
    // Chip select high clears the link side asynchronously; the serial
    // clock is low at the chip select fall, so the release is clean.

    // Ready level handed to the link side
    logic done_link;
    logic next_done_link;

    // Link side state
    logic [11:0] shreg;
    logic [11:0] next_shreg;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic link_bit;
    logic next_link_bit;

    // Link bit back in the system clock
    logic [1:0] bit_sync;

    // Output stage
    logic dout_q;
    logic next_dout_q;
    logic dout_oe_q;
    logic next_dout_oe_q;

    // Ready level next value, from the state register only
    always_comb begin
        next_done_link = (state == ST_DONE);
    end

    // Ready level register, glitch free for the link side
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            done_link <= 1'b0;
        end else begin
            done_link <= next_done_link;
        end
    end

    // Shift register next values: load on the first edge, then shift
    always_comb begin
        next_shreg = shreg;
        next_bit_cnt = bit_cnt;
        next_link_bit = link_bit;
        if (bit_cnt == BIT_CNT_RESET) begin
            // Edges before the end of conversion break the protocol; hold
            if (done_link) begin
                next_link_bit = result[11];
                next_shreg = {result[10:0], 1'b0};
                next_bit_cnt = 4'h1;
            end
        end else begin
            // Remaining bits, then zeros for any extra edges
            next_link_bit = shreg[11];
            next_shreg = {shreg[10:0], 1'b0};
            if (bit_cnt != FRAME_EDGES) begin
                next_bit_cnt = bit_cnt + 4'h1;
            end
        end
    end

    // Link registers on falling serial clock, cleared while deselected
    always_ff @(negedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            shreg <= RESULT_RESET;
            bit_cnt <= BIT_CNT_RESET;
            link_bit <= 1'b1; // Marker level before the first edge
        end else begin
            shreg <= next_shreg;
            bit_cnt <= next_bit_cnt;
            link_bit <= next_link_bit;
        end
    end

    // Output stage next values: low while converting, then marker and data
    always_comb begin
        next_dout_oe_q = !cs_sync[1];
        if (cs_sync[1] || state != ST_DONE) begin
            next_dout_q = 1'b0;
        end else begin
            next_dout_q = bit_sync[1];
        end
    end

    // Link bit synchroniser and output registers
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            bit_sync <= 2'h3;
            dout_q <= 1'b0;
            dout_oe_q <= 1'b0;
        end else begin
            bit_sync <= {bit_sync[0], link_bit};
            dout_q <= next_dout_q;
            dout_oe_q <= next_dout_oe_q;
        end
    end

    // Outputs straight from their registers
    assign dout_out = dout_q;
    assign dout_oe_out = dout_oe_q;
endmodule

// *** sim/serial_adc_convert_readout_properties.sv ***
module serial_adc_convert_readout_properties
    import adc_ctrl_pkg::*;
#(
    parameter int CONV_COUNT = CONV_CYCLES
) (
    input wire logic clk_sys_in, // System clock
    input wire logic srst_in, // Reset
    input wire logic sclk_in, // Serial clock
    input wire logic cs_n_in, // Chip select
    input wire logic pd_drive_in, // Pin driven
    input wire logic pd_level_in, // Pin level
    input wire logic [11:0] sample_in, // Result
    input wire logic dout_out, // Serial data
    input wire logic dout_oe_out, // Output enable
    input wire logic track_out, // Tracking
    input wire logic ref_en_out, // Reference
    input wire logic shutdown_out // Shutdown
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int EOC_MAX = CONV_COUNT + 12;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    // Selected while awake with the serial clock parked
    sequence s_selected;
        (!cs_n_in && !shutdown_out && !sclk_in)[*6];
    endsequence
    sequence s_enabled;
        $rose(dout_oe_out) && !shutdown_out;
    endsequence
    a_hiz_deselected: assert property (cs_n_in[*4] |-> !dout_oe_out)
        else $error("output driven while deselected");
    a_enable_on_select: assert property (s_selected |-> dout_oe_out)
        else $error("no output enable after select");
    a_low_when_enabled: assert property (s_enabled |-> !dout_out)
        else $error("output not low at conversion start");
    a_hold_on_start: assert property (s_enabled |-> !track_out)
        else $error("still tracking after start");
    a_eoc_in_time: assert property (s_enabled |-> ##[1:EOC_MAX] (dout_out || cs_n_in))
        else $error("end of conversion late");
    a_stable_sclk_high: assert property ((sclk_in && !cs_n_in)[*6] |-> $stable(dout_out))
        else $error("output changed without a falling edge");
    a_track_deselected: assert property (cs_n_in[*5] |-> track_out)
        else $error("not tracking while deselected");
    a_shutdown_low: assert property ((pd_drive_in && !pd_level_in)[*4] |-> shutdown_out)
        else $error("no shutdown with pin low");
    a_ref_high: assert property ((pd_drive_in && pd_level_in)[*4] |-> ref_en_out && !shutdown_out)
        else $error("reference off with pin high");
    a_ref_float: assert property ((!pd_drive_in)[*4] |-> !ref_en_out && !shutdown_out)
        else $error("wrong mode with pin floating");
endmodule

// *** sim/adc_host_model.sv ***
module adc_host_model (
    input wire logic dout_in, // Serial data from device
    input wire logic dout_oe_in, // Device driving the line
    output logic sclk_out, // Serial clock
    output logic cs_n_out // Chip select
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
    end
    // Start, wait for the marker with clock parked, then shift bits in on rises
    task automatic frame(input int edges, output logic eoc, output logic [15:0] bits);
        eoc = 1'b0;
        bits = '0;
        cs_n_out = 1'b0;
        for (int i = 0; i < 400 && !eoc; i++) begin
            #40 eoc = dout_oe_in & dout_in;
        end
        for (int i = 0; i < edges && eoc; i++) begin
            #240 sclk_out = 1'b1;
            bits = {bits[14:0], dout_oe_in ? dout_in : 1'bx};
            #240 sclk_out = 1'b0;
        end
        #240 cs_n_out = 1'b1;
        #1500;
    endtask
    // Select briefly, deselect before the end of conversion
    task automatic abort(input int hold);
        cs_n_out = 1'b0;
        #hold cs_n_out = 1'b1;
    endtask
endmodule

// *** sim/test_serial_adc_convert_readout.sv ***
module test_serial_adc_convert_readout;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_in = 1'b0;
    logic srst_in = 1'b1;
    logic sclk, cs_n, dout_out, dout_oe_out, track_out, ref_en_out, shutdown_out, eoc;
    logic pd_drive_in = 1'b1;
    logic pd_level_in = 1'b1;
    logic [11:0] sample_in = 12'h000;
    logic [15:0] bits;
    int err_total = 0;
    int samples_checked = 0;
    always #20 clk_sys_in = ~clk_sys_in;
    serial_adc_convert_readout #(.CONV_COUNT(8)) u_serial_adc_convert_readout (.clk_sys_in(clk_sys_in),
        .srst_in(srst_in), .sclk_in(sclk), .cs_n_in(cs_n), .pd_drive_in(pd_drive_in), .pd_level_in(pd_level_in),
        .sample_in(sample_in), .dout_out(dout_out), .dout_oe_out(dout_oe_out), .track_out(track_out),
        .ref_en_out(ref_en_out), .shutdown_out(shutdown_out));
    adc_host_model u_adc_host_model (.dout_in(dout_out), .dout_oe_in(dout_oe_out), .sclk_out(sclk), .cs_n_out(cs_n));
    // Compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Two frames back to back, the first with trailing zeros
    task automatic t_readout();
        @(posedge clk_sys_in) #1 sample_in = 12'hA5C;
        u_adc_host_model.frame(15, eoc, bits);
        check("stream", bits, {1'b0, 1'b1, 12'hA5C, 2'b00});
        check("released", {dout_oe_out, track_out}, 16'h0001);
        @(posedge clk_sys_in) #1 sample_in = 12'h001;
        u_adc_host_model.frame(13, eoc, bits);
        check("second", bits, {3'h0, 1'b1, 12'h001});
        $display("readout done");
    endtask
    // Deselect mid conversion, then convert again
    task automatic t_abort();
        fork
            u_adc_host_model.abort(240);
            #180 check("hold", {13'h0, dout_oe_out, dout_out, track_out}, 16'h0004);
        join
        #1500 check("aborted", {dout_oe_out, track_out}, 16'h0001);
        @(posedge clk_sys_in) #1 sample_in = 12'hFFF;
        u_adc_host_model.frame(13, eoc, bits);
        check("recovered", bits, {3'h0, 1'b1, 12'hFFF});
        $display("abort done");
    endtask
    // Pin high, low, floating
    task automatic t_modes();
        logic [1:0] pin [3] = '{2'b11, 2'b10, 2'b00};
        logic [1:0] exp [3] = '{2'b01, 2'b10, 2'b00};
        for (int m = 0; m < 3; m++) begin
            @(posedge clk_sys_in) #1 {pd_drive_in, pd_level_in} = pin[m];
            repeat (5) @(posedge clk_sys_in);
            #1 check("mode", {14'h0, shutdown_out, ref_en_out}, {14'h0, exp[m]});
            u_adc_host_model.frame(13, eoc, bits);
            check("started", {15'h0, eoc}, {15'h0, m != 1});
        end
        @(posedge clk_sys_in) #1 {pd_drive_in, pd_level_in} = 2'b11;
        $display("modes done");
    endtask
    initial begin
        repeat (10) @(posedge clk_sys_in);
        #1 srst_in = 1'b0;
        repeat (3) @(posedge clk_sys_in);
        t_readout();
        t_abort();
        t_modes();
        results();
    end
    // Watchdog
    initial begin
        #200000;
        err_total++;
        results();
    end
endmodule
bind serial_adc_convert_readout serial_adc_convert_readout_properties #(.CONV_COUNT(CONV_COUNT)) u_props (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in), .pd_drive_in(pd_drive_in),
    .pd_level_in(pd_level_in), .sample_in(sample_in), .dout_out(dout_out), .dout_oe_out(dout_oe_out),
    .track_out(track_out), .ref_en_out(ref_en_out), .shutdown_out(shutdown_out));
